// >>> rtl/cfco_cfg.svh
// Constants for the cache flush, coherence and ordering block
`ifndef CFCO_CFG_SVH
`define CFCO_CFG_SVH
`define CFCO_ADDR_W 32
`define CFCO_DATA_W 32
`define CFCO_L2_BLK 64
`define CFCO_DC_LINE 16
`define CFCO_IC_LINE 32
`define CFCO_L2_OFS_W 6
`define CFCO_DC_OFS_W 4
`define CFCO_IC_OFS_W 5
`define CFCO_SETS 16
`define CFCO_SET_W 4
`define CFCO_WAYS 4
`define CFCO_WAY_W 2
`define CFCO_TAG_W 22
`define CFCO_FT_SPEC_E 4'h2
`define CFCO_FT_ATOM_NC 4'h4
`define CFCO_FT_NONE 4'h0
`define CFCO_REG_CTRL 4'h0
`define CFCO_REG_STAT 4'h4
`define CFCO_REG_FAULT 4'h8
`define CFCO_REG_FADDR 4'hC
`define CFCO_CTRL_DMAP 0
`define CFCO_CTRL_TSO 1
`endif

// >>> rtl/cfco_pkg.sv
// Types for the cache flush, coherence and ordering block
`include "cfco_cfg.svh"
package cfco_pkg;
   typedef enum logic [2:0] {
      CFCO_OP_LOAD, CFCO_OP_STORE, CFCO_OP_ATOMIC, CFCO_OP_IFLUSH,
      CFCO_OP_L2FLUSH, CFCO_OP_DIAG_INV
   } cfco_op_type;
   typedef struct packed {
      cfco_op_type op;
      logic [`CFCO_ADDR_W-1:0] addr;
      logic [`CFCO_DATA_W-1:0] wdata;
      logic [3:0] be;
      logic cacheable;
      logic side_effect;
      logic speculative;
   } cfco_req_type;
   typedef struct packed {
      logic valid;
      logic dirty;
      logic [`CFCO_TAG_W-1:0] tag;
   } cfco_tag_type;
endpackage : cfco_pkg

// >>> rtl/cfco_tag_mem.sv
// Tag store of the second-level cache, registered read data
`timescale 1ns/1ps
`include "cfco_cfg.svh"
module cfco_tag_mem
   import cfco_pkg::*;
(
   // Clocking
   input wire logic clk,
   input wire logic ce,
   // Read port
   input wire logic [`CFCO_SET_W-1:0] rd_set,
   output cfco_tag_type rd_data [`CFCO_WAYS],
   // Write port
   input wire logic wr_en,
   input wire logic [`CFCO_SET_W-1:0] wr_set,
   input wire logic [`CFCO_WAY_W-1:0] wr_way,
   input cfco_tag_type wr_data
);
   cfco_tag_type mem [`CFCO_SETS][`CFCO_WAYS];
   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         mem[wr_set][wr_way] <= wr_data;
      end
   end
   genvar w;
   generate
      for (w = 0; w < `CFCO_WAYS; w++) begin : g_rd
         always_ff @(posedge clk) begin
            if (ce) begin
               rd_data[w] <= mem[rd_set][w];
            end
         end
      end
   endgenerate
endmodule : cfco_tag_mem

// >>> rtl/cfco_core.sv
// Cache flush, coherence and memory-ordering controller
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "cfco_cfg.svh"
module cfco_core
   import cfco_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   // Register bus (Avalon-MM)
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Requests from virtual cores
   input wire logic req_valid,
   input cfco_req_type req,
   output logic req_ready,
   output logic rsp_done,
   output logic rsp_fault,
   // Memory side
   output logic mem_valid,
   output logic mem_write,
   output logic [`CFCO_ADDR_W-1:0] mem_addr,
   output logic [3:0] mem_be,
   output logic [`CFCO_DATA_W-1:0] mem_wdata,
   input wire logic mem_ack,
   // First-level cache control
   output logic dc_inv,
   output logic ic_inv,
   output logic [`CFCO_ADDR_W-1:0] l1_inv_addr,
   output logic fetch_buf_clr
);
   typedef enum logic [2:0] {
      S_IDLE, S_LOOK, S_WB, S_FILL, S_NC, S_DONE
   } cfco_state_type;
   cfco_state_type state_q;
   cfco_req_type cur_q;
   logic dmap_q, tso_q, fault_v_q;
   logic [3:0] fault_kind_field_q;
   logic [`CFCO_ADDR_W-1:0] fault_addr_q;
   logic [`CFCO_WAY_W-1:0] way_q, rr_q;
   logic [`CFCO_ADDR_W-1:0] wb_addr_q;
   logic [`CFCO_ADDR_W-1:0] mem_addr_q;
   logic mem_valid_q, mem_write_q;
   logic [3:0] mem_be_q;
   logic [`CFCO_DATA_W-1:0] mem_wdata_q;
   logic done_q, fault_q, ready_q;
   logic dc_inv_q, ic_inv_q, fbc_q;
   logic [`CFCO_ADDR_W-1:0] l1_addr_q;
   logic [31:0] rdata_q;
   logic wait_q;
   logic store_pend_q;
   cfco_tag_type rd_tag [`CFCO_WAYS];
   logic tw_en;
   logic [`CFCO_WAY_W-1:0] tw_way;
   cfco_tag_type tw_data;
   logic [`CFCO_SET_W-1:0] set_w;
   logic [`CFCO_TAG_W-1:0] tag_w;
   logic hit;
   logic [`CFCO_WAY_W-1:0] hit_way;
   // set and tag split on 64-byte blocks
   assign set_w = cur_q.addr[`CFCO_L2_OFS_W +: `CFCO_SET_W];
   assign tag_w = cur_q.addr[`CFCO_ADDR_W-1 -: `CFCO_TAG_W];
   always_comb begin
      hit = 1'b0;
      hit_way = '0;
      for (int i = 0; i < `CFCO_WAYS; i++) begin
         if (rd_tag[i].valid && rd_tag[i].tag == tag_w) begin
            hit = 1'b1;
            hit_way = i[`CFCO_WAY_W-1:0];
         end
      end
   end
   // ---------------------------------------------------------------
   // Tag store
   // ---------------------------------------------------------------
   cfco_tag_mem u_tags (
      .clk(clk),
      .ce(ce),
      .rd_set(req_valid && ready_q ?
              req.addr[`CFCO_L2_OFS_W +: `CFCO_SET_W] : set_w),
      .rd_data(rd_tag),
      .wr_en(tw_en),
      .wr_set(set_w),
      .wr_way(tw_way),
      .wr_data(tw_data)
   );
   // ---------------------------------------------------------------
   // Register bus: one wait cycle per access
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_q <= 1'b1;
      end else if (ce) begin
         wait_q <= !(avs_read || avs_write) || !wait_q;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dmap_q <= 1'b0;
         tso_q <= 1'b1;
      end else if (ce && avs_write && wait_q &&
                   avs_address == `CFCO_REG_CTRL) begin
         dmap_q <= avs_writedata[`CFCO_CTRL_DMAP];
         tso_q <= avs_writedata[`CFCO_CTRL_TSO];
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= '0;
      end else if (ce && avs_read && wait_q) begin
         case (avs_address)
            `CFCO_REG_CTRL: rdata_q <= {30'h0, tso_q, dmap_q};
            `CFCO_REG_STAT: rdata_q <= {27'h0, store_pend_q, fault_v_q,
                                        state_q};
            `CFCO_REG_FAULT: rdata_q <= {28'h0, fault_kind_field_q};
            `CFCO_REG_FADDR: rdata_q <= fault_addr_q;
            default: rdata_q <= '0;
         endcase
      end
   end
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   // ---------------------------------------------------------------
   // Fault recording; a new fault wins over a software clear
   // ---------------------------------------------------------------
   logic fault_now;
   logic [3:0] fault_kind_d;
   always_comb begin
      fault_now = 1'b0;
      fault_kind_d = `CFCO_FT_NONE;
      if (req.op == CFCO_OP_LOAD && req.speculative &&
          req.side_effect) begin
         fault_now = 1'b1;
         fault_kind_d = `CFCO_FT_SPEC_E;
      end else if (req.op == CFCO_OP_ATOMIC && !req.cacheable) begin
         fault_now = 1'b1;
         fault_kind_d = `CFCO_FT_ATOM_NC;
      end
   end
   logic take;
   assign take = req_valid && ready_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_v_q <= 1'b0;
         fault_kind_field_q <= `CFCO_FT_NONE;
         fault_addr_q <= '0;
      end else if (ce) begin
         if (take && fault_now) begin
            fault_v_q <= 1'b1;
            fault_kind_field_q <= fault_kind_d;
            fault_addr_q <= req.addr;
         end else if (avs_write && wait_q &&
                      avs_address == `CFCO_REG_FAULT) begin
            fault_v_q <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Request sequencer; one access at a time keeps program order
   // ---------------------------------------------------------------
   // only one access is outstanding, so order is total
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         mem_valid_q <= 1'b0;
         mem_write_q <= 1'b0;
         mem_addr_q <= '0;
         mem_be_q <= '0;
         mem_wdata_q <= '0;
         way_q <= '0;
         wb_addr_q <= '0;
         store_pend_q <= 1'b0;
      end else if (ce) begin
         done_q <= 1'b0;
         fault_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (take) begin
                  cur_q <= req;
                  ready_q <= 1'b0;
                  if (fault_now) begin
                     fault_q <= 1'b1;
                     state_q <= S_DONE;
                  end else if (!req.cacheable) begin
                     mem_valid_q <= 1'b1;
                     mem_write_q <= req.op == CFCO_OP_STORE;
                     mem_addr_q <= req.addr;
                     mem_be_q <= req.be;
                     mem_wdata_q <= req.wdata;
                     state_q <= S_NC;
                  end else begin
                     state_q <= S_LOOK;
                  end
               end
            end
            S_LOOK: begin
               if (cur_q.op == CFCO_OP_IFLUSH) begin
                  state_q <= S_DONE;
               end else if (cur_q.op == CFCO_OP_DIAG_INV) begin
                  state_q <= S_DONE;
               end else if (hit && cur_q.op != CFCO_OP_L2FLUSH) begin
                  way_q <= hit_way;
                  if (cur_q.op != CFCO_OP_LOAD) begin
                     store_pend_q <= 1'b1;
                     mem_valid_q <= 1'b1;
                     mem_write_q <= 1'b1;
                     mem_addr_q <= cur_q.addr;
                     mem_be_q <= cur_q.be;
                     mem_wdata_q <= cur_q.wdata;
                     state_q <= S_FILL;
                  end else begin
                     state_q <= S_DONE;
                  end
               end else begin
                  // direct map picks way from address bits above set
                  way_q <= cur_q.op == CFCO_OP_L2FLUSH ? hit_way :
                     dmap_q ? tag_w[`CFCO_WAY_W-1:0] : rr_q;
                  if ((cur_q.op == CFCO_OP_L2FLUSH && hit &&
                       rd_tag[hit_way].dirty) ||
                      (cur_q.op != CFCO_OP_L2FLUSH &&
                       rd_tag[dmap_q ? tag_w[`CFCO_WAY_W-1:0] : rr_q].valid &&
                       rd_tag[dmap_q ? tag_w[`CFCO_WAY_W-1:0] : rr_q].dirty))
                  begin
                     wb_addr_q <= {cur_q.op == CFCO_OP_L2FLUSH ?
                        rd_tag[hit_way].tag :
                        rd_tag[dmap_q ? tag_w[`CFCO_WAY_W-1:0] : rr_q].tag,
                        set_w, `CFCO_L2_OFS_W'(0)};
                     mem_valid_q <= 1'b1;
                     mem_write_q <= 1'b1;
                     mem_be_q <= 4'hF;
                     mem_addr_q <= {cur_q.op == CFCO_OP_L2FLUSH ?
                        rd_tag[hit_way].tag :
                        rd_tag[dmap_q ? tag_w[`CFCO_WAY_W-1:0] : rr_q].tag,
                        set_w, `CFCO_L2_OFS_W'(0)};
                     state_q <= S_WB;
                  end else if (cur_q.op == CFCO_OP_L2FLUSH) begin
                     state_q <= S_DONE;
                  end else begin
                     mem_valid_q <= 1'b1;
                     mem_write_q <= cur_q.op != CFCO_OP_LOAD;
                     mem_addr_q <= cur_q.addr;
                     mem_be_q <= cur_q.be;
                     mem_wdata_q <= cur_q.wdata;
                     store_pend_q <= cur_q.op != CFCO_OP_LOAD;
                     state_q <= S_FILL;
                  end
               end
            end
            S_WB: begin
               if (mem_ack) begin
                  if (cur_q.op == CFCO_OP_L2FLUSH) begin
                     mem_valid_q <= 1'b0;
                     state_q <= S_DONE;
                  end else begin
                     mem_write_q <= cur_q.op != CFCO_OP_LOAD;
                     mem_addr_q <= cur_q.addr;
                     mem_be_q <= cur_q.be;
                     mem_wdata_q <= cur_q.wdata;
                     store_pend_q <= cur_q.op != CFCO_OP_LOAD;
                     state_q <= S_FILL;
                  end
               end
            end
            S_FILL, S_NC: begin
               if (mem_ack) begin
                  mem_valid_q <= 1'b0;
                  store_pend_q <= 1'b0;
                  state_q <= S_DONE;
               end
            end
            S_DONE: begin
               done_q <= 1'b1;
               ready_q <= 1'b1;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Tag updates
   // ---------------------------------------------------------------
   always_comb begin
      tw_en = 1'b0;
      tw_way = way_q;
      tw_data = '0;
      if (state_q == S_LOOK && cur_q.op == CFCO_OP_DIAG_INV && hit) begin
         tw_en = 1'b1;
         tw_way = hit_way;
      end else if (state_q == S_DONE && cur_q.op == CFCO_OP_L2FLUSH) begin
         tw_en = 1'b1;
      end else if (state_q == S_FILL && mem_ack) begin
         tw_en = 1'b1;
         tw_data.valid = 1'b1;
         tw_data.dirty = cur_q.op != CFCO_OP_LOAD;
         tw_data.tag = tag_w;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rr_q <= '0;
      end else if (ce && tw_en && tw_data.valid && !dmap_q) begin
         rr_q <= rr_q + 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // First-level invalidation and fetch buffer clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dc_inv_q <= 1'b0;
         ic_inv_q <= 1'b0;
         fbc_q <= 1'b0;
         l1_addr_q <= '0;
      end else if (ce) begin
         dc_inv_q <= tw_en && state_q != S_FILL;
         ic_inv_q <= (tw_en && state_q != S_FILL) ||
            (state_q == S_DONE && cur_q.op == CFCO_OP_IFLUSH);
         fbc_q <= state_q == S_DONE && cur_q.op == CFCO_OP_IFLUSH;
         l1_addr_q <= {cur_q.addr[`CFCO_ADDR_W-1:`CFCO_L2_OFS_W],
                       `CFCO_L2_OFS_W'(0)};
      end
   end
   assign req_ready = ready_q;
   assign rsp_done = done_q;
   assign rsp_fault = fault_q;
   assign mem_valid = mem_valid_q;
   assign mem_write = mem_write_q;
   assign mem_addr = mem_addr_q;
   assign mem_be = mem_be_q;
   assign mem_wdata = mem_wdata_q;
   assign dc_inv = dc_inv_q;
   assign ic_inv = ic_inv_q;
   assign l1_inv_addr = l1_addr_q;
   assign fetch_buf_clr = fbc_q;
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   spec_fault_kind_a: assert property (
      take && req.op == CFCO_OP_LOAD && req.speculative && req.side_effect
      |=> fault_v_q && fault_kind_field_q == `CFCO_FT_SPEC_E)
      else $error("spec fault kind wrong");
   atom_nc_kind_a: assert property (
      take && req.op == CFCO_OP_ATOMIC && !req.cacheable
      |=> fault_q && !mem_valid_q && fault_kind_field_q == `CFCO_FT_ATOM_NC)
      else $error("atomic nc not faulted");
   diag_nowb_a: assert property (state_q == S_LOOK &&
      cur_q.op == CFCO_OP_DIAG_INV |=> !mem_valid_q)
      else $error("diag invalidate wrote back");
   one_out_a: assert property (mem_valid_q |-> !ready_q)
      else $error("second access issued");
   nc_exact_a: assert property (state_q == S_NC |->
      mem_addr_q == cur_q.addr && mem_be_q == cur_q.be)
      else $error("nc access altered");
   iflush_clr_a: assert property (state_q == S_DONE &&
      cur_q.op == CFCO_OP_IFLUSH |=> fetch_buf_clr)
      else $error("fetch buffers not cleared");
   wb_first_a: assert property (state_q == S_WB && mem_ack &&
      cur_q.op != CFCO_OP_L2FLUSH |=> state_q == S_FILL)
      else $error("fill before writeback");
   dmap_way_a: assert property (state_q == S_LOOK && dmap_q && !hit &&
      cur_q.op == CFCO_OP_LOAD |=> way_q == $past(tag_w[`CFCO_WAY_W-1:0]))
      else $error("direct map way wrong");
   cov_wb_c: cover property (state_q == S_WB ##[1:20] state_q == S_FILL);
   cov_nc_c: cover property (state_q == S_NC ##[1:20] rsp_done);
   cov_flt_c: cover property (rsp_fault);
endmodule : cfco_core

// >>> sim/cfco_mem_model.sv
// Behavioural memory behind the block, answering after a set delay
`timescale 1ns/1ps
`include "cfco_cfg.svh"
module cfco_mem_model
   import cfco_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Requests from the block
   input wire logic mem_valid,
   input wire logic mem_write,
   input wire logic [`CFCO_ADDR_W-1:0] mem_addr,
   input wire logic [3:0] mem_be,
   input wire logic [`CFCO_DATA_W-1:0] mem_wdata,
   // Answer
   input wire logic [3:0] delay,
   output logic mem_ack
);
   logic [3:0] wait_q;
   logic [`CFCO_ADDR_W-1:0] log_addr[$];
   logic log_wr[$];
   logic [3:0] log_be[$];
   logic [`CFCO_DATA_W-1:0] log_wd[$];

   // Each request is logged once, at the edge of its acknowledge
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         wait_q <= 4'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         wait_q <= 4'h0;
      end else if (mem_valid === 1'b1) begin
         if (wait_q >= delay) begin
            mem_ack <= 1'b1;
            log_addr.push_back(mem_addr);
            log_wr.push_back(mem_write);
            log_be.push_back(mem_be);
            log_wd.push_back(mem_wdata);
         end else begin
            wait_q <= wait_q + 4'h1;
         end
      end
   end
endmodule : cfco_mem_model

// >>> sim/test_cache_flush_coherence_ordering.sv
// Self-checking bench for the flush, coherence and ordering block
`timescale 1ns/1ps
`include "cfco_cfg.svh"
module test_cache_flush_coherence_ordering
   import cfco_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic req_valid = 1'b0;
   cfco_req_type req = '0;
   logic req_ready, rsp_done, rsp_fault, mem_valid, mem_write, mem_ack;
   logic [31:0] mem_addr, mem_wdata, l1_inv_addr, l1_last, rd;
   logic [3:0] mem_be;
   logic [3:0] delay = 4'h0;
   logic dc_inv, ic_inv, fetch_buf_clr, flt;
   int n_errors = 0;
   int comparisons = 0;
   int n_dc, n_ic, n_fb, wi, ri;

   always #4 clk = ~clk;

   cfco_core u_cfco_core (.clk(clk), .arst_n(arst_n), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_done(rsp_done), .rsp_fault(rsp_fault),
      .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .dc_inv(dc_inv), .ic_inv(ic_inv), .l1_inv_addr(l1_inv_addr),
      .fetch_buf_clr(fetch_buf_clr));

   cfco_mem_model u_cfco_mem_model (.clk(clk), .arst_n(arst_n),
      .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_be(mem_be), .mem_wdata(mem_wdata), .delay(delay),
      .mem_ack(mem_ack));

   always @(posedge clk) begin
      if (dc_inv === 1'b1) begin
         n_dc++;
         l1_last = l1_inv_addr;
      end
      if (ic_inv === 1'b1) n_ic++;
      if (fetch_buf_clr === 1'b1) n_fb++;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wrap_up;
      $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   // Waitrequest and read data are both taken at the finishing edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
   endtask : bus

   task issue(input cfco_op_type op, input logic [31:0] a,
              input logic [3:0] be, input logic c, input logic e,
              input logic s);
      int n;
      n = 0;
      flt = 1'b0;
      @(posedge clk);
      req <= '{op, a, a ^ 32'h5A5A_0000, be, c, e, s};
      req_valid <= 1'b1;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 200) begin
         n++;
         @(negedge clk);
      end
      @(posedge clk);
      req_valid <= 1'b0;
      do begin
         @(negedge clk);
         if (rsp_fault === 1'b1) flt = 1'b1;
         n++;
      end while (rsp_done !== 1'b1 && n < 500);
      if (n >= 500) chk(32'h1, 32'h0);
      // Pulses that rise with done are counted at the next edge
      @(negedge clk);
   endtask : issue

   task clr;
      u_cfco_mem_model.log_addr.delete();
      u_cfco_mem_model.log_wr.delete();
      u_cfco_mem_model.log_be.delete();
      u_cfco_mem_model.log_wd.delete();
      n_dc = 0;
      n_ic = 0;
      n_fb = 0;
   endtask : clr

   // Position of the first logged access of a kind to a 64-byte block
   function automatic int find(input logic wr, input logic [31:0] a);
      for (int i = 0; i < u_cfco_mem_model.log_addr.size(); i++)
         if (u_cfco_mem_model.log_wr[i] === wr &&
             u_cfco_mem_model.log_addr[i][31:6] === a[31:6]) return i;
      return -1;
   endfunction : find

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      chk({31'h0, req_ready}, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk({30'h0, rd[1:0]}, 32'h2);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
   endtask : t_reset

   task t_nc_byte;
      clr();
      delay <= 4'h5;
      issue(CFCO_OP_LOAD, 32'h8000_0013, 4'h2, 1'b0, 1'b0, 1'b0);
      chk(u_cfco_mem_model.log_addr.size(), 32'h1);
      chk(u_cfco_mem_model.log_addr[0], 32'h8000_0013);
      chk({28'h0, u_cfco_mem_model.log_be[0]}, 32'h2);
      delay <= 4'h0;
   endtask : t_nc_byte

   task t_se_order;
      clr();
      for (int i = 0; i < 3; i++)
         issue(CFCO_OP_STORE, 32'h9000_0100 - i * 4, 4'hF, 1'b0, 1'b1, 1'b0);
      chk(u_cfco_mem_model.log_addr.size(), 32'h3);
      for (int i = 0; i < 3; i++) begin
         rd = 32'h9000_0100 - i * 4;
         chk(u_cfco_mem_model.log_addr[i], rd);
         chk(u_cfco_mem_model.log_wd[i], rd ^ 32'h5A5A_0000);
      end
   endtask : t_se_order

   task t_faults;
      clr();
      issue(CFCO_OP_LOAD, 32'h9000_0200, 4'hF, 1'b0, 1'b1, 1'b1);
      chk({31'h0, flt}, 32'h1);
      bus(1'b0, `CFCO_REG_FAULT, 32'h0);
      chk({28'h0, rd[3:0]}, 32'h2);
      issue(CFCO_OP_ATOMIC, 32'h8000_0040, 4'hF, 1'b0, 1'b0, 1'b0);
      chk({31'h0, flt}, 32'h1);
      bus(1'b0, `CFCO_REG_FAULT, 32'h0);
      chk({28'h0, rd[3:0]}, 32'h4);
      bus(1'b0, `CFCO_REG_FADDR, 32'h0);
      chk(rd, 32'h8000_0040);
      bus(1'b0, `CFCO_REG_STAT, 32'h0);
      chk({31'h0, rd[3]}, 32'h1);
      bus(1'b1, `CFCO_REG_FAULT, 32'h0);
      bus(1'b0, `CFCO_REG_STAT, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
      chk(u_cfco_mem_model.log_addr.size(), 32'h0);
      issue(CFCO_OP_ATOMIC, 32'h0000_0340, 4'hF, 1'b1, 1'b0, 1'b0);
      chk({31'h0, flt}, 32'h0);
      issue(CFCO_OP_LOAD, 32'h0000_0380, 4'hF, 1'b1, 1'b1, 1'b0);
      chk({31'h0, flt}, 32'h0);
   endtask : t_faults

   task t_iflush;
      issue(CFCO_OP_STORE, 32'h0000_0500, 4'hF, 1'b1, 1'b0, 1'b0);
      clr();
      issue(CFCO_OP_IFLUSH, 32'h0000_0500, 4'hF, 1'b1, 1'b0, 1'b0);
      chk({31'h0, n_ic > 0}, 32'h1);
      chk({31'h0, n_fb > 0}, 32'h1);
      chk(find(1'b1, 32'h0000_0500), -1);
   endtask : t_iflush

   task t_l2flush;
      issue(CFCO_OP_STORE, 32'h0000_1048, 4'hF, 1'b1, 1'b0, 1'b0);
      clr();
      issue(CFCO_OP_L2FLUSH, 32'h0000_1048, 4'hF, 1'b1, 1'b0, 1'b0);
      chk({31'h0, find(1'b1, 32'h0000_1048) >= 0}, 32'h1);
      chk({31'h0, n_dc > 0 && n_ic > 0}, 32'h1);
      chk({6'h0, l1_last[31:6]}, 32'h0000_0041);
      issue(CFCO_OP_STORE, 32'h0000_1188, 4'hF, 1'b1, 1'b0, 1'b0);
      clr();
      issue(CFCO_OP_DIAG_INV, 32'h0000_1188, 4'hF, 1'b1, 1'b0, 1'b0);
      chk(find(1'b1, 32'h0000_1188), -1);
   endtask : t_l2flush

   // Same set and same low tag bits, so both land in one direct-map way
   // Block 20C0 is loaded first into a round-robin way off its direct way
   task t_dmap;
      issue(CFCO_OP_LOAD, 32'h0000_20C0, 4'hF, 1'b1, 1'b0, 1'b0);
      bus(1'b1, `CFCO_REG_CTRL, 32'h3);
      issue(CFCO_OP_STORE, 32'h0000_2080, 4'hF, 1'b1, 1'b0, 1'b0);
      clr();
      delay <= 4'h3;
      issue(CFCO_OP_LOAD, 32'h0000_3080, 4'hF, 1'b1, 1'b0, 1'b0);
      wi = find(1'b1, 32'h0000_2080);
      ri = find(1'b0, 32'h0000_3080);
      chk({31'h0, wi >= 0}, 32'h1);
      chk({31'h0, wi < ri}, 32'h1);
      clr();
      issue(CFCO_OP_LOAD, 32'h0000_3084, 4'hF, 1'b1, 1'b0, 1'b0);
      chk(u_cfco_mem_model.log_addr.size(), 32'h0);
      issue(CFCO_OP_LOAD, 32'h0000_20C0, 4'hF, 1'b1, 1'b0, 1'b0);
      issue(CFCO_OP_LOAD, 32'h0000_30C0, 4'hF, 1'b1, 1'b0, 1'b0);
      clr();
      issue(CFCO_OP_LOAD, 32'h0000_20C0, 4'hF, 1'b1, 1'b0, 1'b0);
      chk(u_cfco_mem_model.log_addr.size(), 32'h0);
      bus(1'b1, `CFCO_REG_CTRL, 32'h2);
      delay <= 4'h0;
   endtask : t_dmap

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_nc_byte();
      t_se_order();
      t_faults();
      t_iflush();
      t_l2flush();
      t_dmap();
      wrap_up();
   end

   // Every scenario finishes within a few thousand cycles
   initial begin
      #320000;
      n_errors++;
      wrap_up();
   end
endmodule : test_cache_flush_coherence_ordering
